//--- core/oprh_regs.sv
// Periodic start, low-speed threshold and first root hub descriptor register bank.
`timescale 1ns/1ps
module oprh_regs #(
	parameter logic [oprh_pkg::NDP_W-1:0] DOWNSTREAM_PORT_COUNT = oprh_pkg::NDP_DEF
) (
	input  wire logic                       i_mclk,
	input  wire logic                       i_nrst,
	input  wire logic                       i_reg_wr,
	input  wire logic                       i_reg_rd,
	input  wire logic [oprh_pkg::ADDR_W-1:0] i_reg_addr,
	input  wire logic [oprh_pkg::DATA_W-1:0] i_reg_wdata,
	output logic      [oprh_pkg::DATA_W-1:0] o_reg_rdata,
	output logic                            o_reg_rvalid,
	input  wire logic [oprh_pkg::FR_W-1:0]   i_frame_remaining,
	input  wire logic                       i_frame_start,
	input  wire logic                       i_xfer_busy,
	output logic                            o_periodic_priority,
	output logic                            o_periodic_go,
	output logic                            o_ls_start_ok,
	output logic      [oprh_pkg::PGD_W-1:0]  o_power_good_delay,
	output logic                            o_no_power_switching,
	output logic                            o_power_switch_mode,
	output logic                            o_pwr_per_port,
	output logic                            o_no_overcurrent_protect,
	output logic                            o_overcurrent_report_mode,
	output logic                            o_oc_per_port,
	output logic                            o_oc_collective,
	output logic      [oprh_pkg::NDP_W-1:0]  o_downstream_port_count
);
	import oprh_pkg::*;

	typedef struct packed {
		logic [PS_W-1:0]   per_start;
		logic [LST_W-1:0]  ls_thr;
		logic [PGD_W-1:0]  pgd;
		logic              no_overcurrent_protect;
		logic              overcurrent_report_mode;
		logic              no_power_switching;
		logic              power_switch_mode;
		logic [DATA_W-1:0] rdata;
		logic              rvalid;
		logic              ls_ok;
		logic              pw_per_port;
		logic              oc_per_port;
		logic              oc_all;
	} oprh_regs_s;

	oprh_regs_s      st_r;
	oprh_regs_s      st_nxt;
	logic [DATA_W-1:0] desc_a;

	// Read-only fields are built here, so writes can never reach them.
	always_comb begin
		desc_a                                  = '0;
		desc_a[POS_PGD_LO +: PGD_W]             = st_r.pgd;
		desc_a[POS_NO_OVERCURRENT_PROTECT]                        = st_r.no_overcurrent_protect;
		desc_a[POS_OVERCURRENT_REPORT_MODE]                        = st_r.overcurrent_report_mode;
		desc_a[POS_DT]                          = DT_VAL;
		desc_a[POS_NPS]                         = st_r.no_power_switching;
		desc_a[POS_PSM]                         = st_r.power_switch_mode;
		desc_a[POS_NDP_LO +: NDP_W]             = DOWNSTREAM_PORT_COUNT;
	end

	always_comb begin
		st_nxt        = st_r;
		st_nxt.rvalid = i_reg_rd;
		if (i_reg_rd) begin
			case (i_reg_addr)
				OFS_PER_START: begin
					st_nxt.rdata = {{(DATA_W-PS_W){1'b0}}, st_r.per_start};
				end
				OFS_LS_THR: begin
					st_nxt.rdata = {{(DATA_W-LST_W){1'b0}}, st_r.ls_thr};
				end
				OFS_RH_DESC_A: begin
					st_nxt.rdata = desc_a;
				end
				default: begin
					st_nxt.rdata = RDATA_UNMAPPED;
				end
			endcase
		end
		// Reserved bits are not stored, so a careless write cannot upset them.
		if (i_reg_wr) begin
			case (i_reg_addr)
				OFS_PER_START: begin
					st_nxt.per_start = i_reg_wdata[PS_W-1:0];
				end
				OFS_LS_THR: begin
					st_nxt.ls_thr = i_reg_wdata[LST_W-1:0];
				end
				OFS_RH_DESC_A: begin
					st_nxt.pgd  = i_reg_wdata[POS_PGD_LO +: PGD_W];
					st_nxt.no_overcurrent_protect = i_reg_wdata[POS_NO_OVERCURRENT_PROTECT];
					st_nxt.overcurrent_report_mode = i_reg_wdata[POS_OVERCURRENT_REPORT_MODE];
					st_nxt.no_power_switching  = i_reg_wdata[POS_NPS];
					st_nxt.power_switch_mode  = i_reg_wdata[POS_PSM];
				end
				default: begin
				end
			endcase
		end
		// Sampled every cycle so a commit decision is never older than one clock.
		st_nxt.ls_ok       = ({2'b00, st_r.ls_thr} <= i_frame_remaining);
		st_nxt.pw_per_port = ~st_r.no_power_switching & st_r.power_switch_mode;
		st_nxt.oc_per_port = ~st_r.no_overcurrent_protect & st_r.overcurrent_report_mode;
		st_nxt.oc_all      = ~st_r.no_overcurrent_protect & ~st_r.overcurrent_report_mode;
	end

	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			st_r           <= '0;
			st_r.per_start <= PS_RST;
			st_r.ls_thr    <= LST_RST;
			st_r.pgd       <= PGD_RST;
			st_r.no_overcurrent_protect      <= NO_OVERCURRENT_PROTECT_RST;
			st_r.overcurrent_report_mode      <= PSM_RST;
			st_r.no_power_switching       <= NPS_RST;
			st_r.power_switch_mode       <= PSM_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	oprh_sched_gate u_gate (
		.i_mclk              (i_mclk),
		.i_nrst              (i_nrst),
		.i_frame_remaining   (i_frame_remaining),
		.i_per_start         (st_r.per_start),
		.i_frame_start       (i_frame_start),
		.i_xfer_busy         (i_xfer_busy),
		.o_periodic_priority (o_periodic_priority),
		.o_periodic_go       (o_periodic_go)
	);

	assign o_reg_rdata               = st_r.rdata;
	assign o_reg_rvalid              = st_r.rvalid;
	assign o_ls_start_ok             = st_r.ls_ok;
	assign o_power_good_delay        = st_r.pgd;
	assign o_no_power_switching      = st_r.no_power_switching;
	assign o_power_switch_mode       = st_r.power_switch_mode;
	assign o_pwr_per_port            = st_r.pw_per_port;
	assign o_no_overcurrent_protect  = st_r.no_overcurrent_protect;
	assign o_overcurrent_report_mode = st_r.overcurrent_report_mode;
	assign o_oc_per_port             = st_r.oc_per_port;
	assign o_oc_collective           = st_r.oc_all;
	assign o_downstream_port_count   = DOWNSTREAM_PORT_COUNT;

	ps_reset_clear_a: assert property (@(posedge i_mclk)
		!i_nrst |=> (st_r.per_start == PS_RST))
		else $error("periodic start not cleared by reset");

	ps_write_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		(i_reg_wr && i_reg_addr == OFS_PER_START) |=>
		(st_r.per_start == $past(i_reg_wdata[PS_W-1:0])))
		else $error("periodic start write lost");

	// Registered derived outputs still hold reset values one edge after release.
	sequence s_settled;
		$past(i_nrst);
	endsequence

	sequence s_oc_gang_steady;
		(!o_no_overcurrent_protect && !o_overcurrent_report_mode) [*2] ##0 s_settled;
	endsequence

	ls_commit_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		s_settled |->
		(o_ls_start_ok == ($past({2'b00, st_r.ls_thr}) <= $past(i_frame_remaining))))
		else $error("low-speed commit disagrees with threshold");

	ls_write_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		(i_reg_wr && i_reg_addr == OFS_LS_THR) |=>
		(st_r.ls_thr == $past(i_reg_wdata[LST_W-1:0])))
		else $error("low-speed threshold write lost");

	oc_write_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		(i_reg_wr && i_reg_addr == OFS_RH_DESC_A) |=>
		((o_no_overcurrent_protect == $past(i_reg_wdata[POS_NO_OVERCURRENT_PROTECT])) &&
		(o_overcurrent_report_mode == $past(i_reg_wdata[POS_OVERCURRENT_REPORT_MODE]))))
		else $error("overcurrent bits write lost");

	oc_all_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		s_oc_gang_steady |-> (o_oc_collective && !o_oc_per_port))
		else $error("collective overcurrent reporting missing");

	pw_sw_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		(!o_no_power_switching && o_power_switch_mode) [*2] ##0 s_settled |-> o_pwr_per_port)
		else $error("per-port power switching missing");

	overcurrent_report_mode_reset_a: assert property (@(posedge i_mclk)
		!i_nrst |=> (o_overcurrent_report_mode == o_power_switch_mode))
		else $error("overcurrent mode does not follow switch mode at reset");

	no_ocp_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		o_no_overcurrent_protect [*2] ##0 s_settled |-> (!o_oc_per_port && !o_oc_collective))
		else $error("overcurrent reported without protection");

	oc_mode_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		(!o_no_overcurrent_protect && o_overcurrent_report_mode) [*2] ##0 s_settled
		|-> o_oc_per_port)
		else $error("per-port overcurrent reporting missing");

	pw_mode_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		o_no_power_switching [*2] ##0 s_settled |-> !o_pwr_per_port)
		else $error("per-port power with switching absent");

	ndp_range_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		(o_downstream_port_count >= NDP_MIN) && (o_downstream_port_count <= NDP_MAX))
		else $error("downstream port count out of range");

	dt_zero_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		(i_reg_rd && i_reg_addr == OFS_RH_DESC_A) |=> (o_reg_rvalid && !o_reg_rdata[POS_DT]))
		else $error("compound device flag read as one");
endmodule : oprh_regs

//--- core/oprh_sched_gate.sv
// Periodic start point detection and the handover from control/bulk to periodic work.
`timescale 1ns/1ps
module oprh_sched_gate (
	input  wire logic                     i_mclk,
	input  wire logic                     i_nrst,
	input  wire logic [oprh_pkg::FR_W-1:0] i_frame_remaining,
	input  wire logic [oprh_pkg::PS_W-1:0] i_per_start,
	input  wire logic                     i_frame_start,
	input  wire logic                     i_xfer_busy,
	output logic                          o_periodic_priority,
	output logic                          o_periodic_go
);
	import oprh_pkg::*;

	typedef struct packed {
		logic prio;
		logic go;
	} oprh_gate_s;

	oprh_gate_s st_r;
	oprh_gate_s st_nxt;
	logic       reach;

	assign reach = (i_frame_remaining == i_per_start);

	always_comb begin
		st_nxt = st_r;
		// A new frame drops the priority; the periodic point of that frame comes later.
		if (i_frame_start) begin
			st_nxt.prio = 1'b0;
		end else if (reach) begin
			st_nxt.prio = 1'b1;
		end
		// A control or bulk transfer in flight is allowed to complete first.
		st_nxt.go = st_nxt.prio & ~i_xfer_busy;
	end

	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_periodic_priority = st_r.prio;
	assign o_periodic_go       = st_r.go;

	sequence s_reach_mid_frame;
		reach && !i_frame_start;
	endsequence

	sequence s_held_in_frame;
		o_periodic_priority && !i_frame_start;
	endsequence

	prio_set_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		s_reach_mid_frame |=> o_periodic_priority)
		else $error("periodic priority not raised at start point");

	prio_hold_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		s_held_in_frame |=> o_periodic_priority)
		else $error("periodic priority dropped inside the frame");

	go_waits_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		i_xfer_busy |=> !o_periodic_go)
		else $error("periodic work started over a busy transfer");

	go_after_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		(s_reach_mid_frame ##0 !i_xfer_busy) |=> o_periodic_go)
		else $error("periodic work not started when idle");
endmodule : oprh_sched_gate

//--- shared/oprh_pkg.sv
// Constants shared by the periodic, low-speed and root hub register bank.
package oprh_pkg;
	localparam int          ADDR_W          = 8;
	localparam int          DATA_W          = 32;
	localparam int          FR_W            = 14;
	localparam int          PS_W            = 14;
	localparam int          LST_W           = 12;
	localparam int          PGD_W           = 8;
	localparam int          NDP_W           = 8;
	// Register offsets.
	localparam logic [7:0]  OFS_PER_START   = 8'h40;
	localparam logic [7:0]  OFS_LS_THR      = 8'h44;
	localparam logic [7:0]  OFS_RH_DESC_A   = 8'h48;
	// Field positions inside the first root hub descriptor.
	localparam int          POS_PGD_LO      = 24;
	localparam int          POS_NO_OVERCURRENT_PROTECT        = 12;
	localparam int          POS_OVERCURRENT_REPORT_MODE        = 11;
	localparam int          POS_DT          = 10;
	localparam int          POS_NPS         = 9;
	localparam int          POS_PSM         = 8;
	localparam int          POS_NDP_LO      = 0;
	// Reset values, fixed read values and port count default and limits.
	localparam logic [13:0] PS_RST          = 14'h0000;
	localparam logic [11:0] LST_RST         = 12'h628;
	localparam logic [7:0]  PGD_RST         = 8'hFF;
	localparam logic        NO_OVERCURRENT_PROTECT_RST        = 1'b0;
	localparam logic        NPS_RST         = 1'b0;
	localparam logic        PSM_RST         = 1'b1;
	localparam logic        DT_VAL          = 1'b0;
	localparam logic [7:0]  NDP_DEF         = 8'h01;
	localparam logic [7:0]  NDP_MIN         = 8'h01;
	localparam logic [7:0]  NDP_MAX         = 8'h0F;
	localparam logic [31:0] RDATA_UNMAPPED  = 32'h0000_0000;
	// Power-good delay unit, for software that converts the byte to time.
	localparam int          PGD_UNIT_MS     = 2;
endpackage : oprh_pkg

//--- tb/testbench.sv
// Self-checking bench for the periodic, low-speed and root hub register bank.
`timescale 1ns/1ps
module testbench;
	import oprh_pkg::*;
	localparam logic [NDP_W-1:0] NDP_TB = 8'h03;
	logic              i_mclk, i_nrst, i_reg_wr, i_reg_rd, i_frame_start, i_xfer_busy;
	logic [ADDR_W-1:0] i_reg_addr;
	logic [DATA_W-1:0] i_reg_wdata, o_reg_rdata;
	logic [FR_W-1:0]   i_frame_remaining;
	logic              o_reg_rvalid, o_periodic_priority, o_periodic_go, o_ls_start_ok;
	logic [PGD_W-1:0]  o_power_good_delay;
	logic              o_no_power_switching, o_power_switch_mode, o_pwr_per_port;
	logic              o_no_overcurrent_protect, o_overcurrent_report_mode;
	logic              o_oc_per_port, o_oc_collective;
	logic [NDP_W-1:0]  o_downstream_port_count;
	int                errors, compares;

	oprh_regs #(.DOWNSTREAM_PORT_COUNT(NDP_TB)) uut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_reg_wr(i_reg_wr),
		.i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
		.o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
		.i_frame_remaining(i_frame_remaining), .i_frame_start(i_frame_start),
		.i_xfer_busy(i_xfer_busy), .o_periodic_priority(o_periodic_priority),
		.o_periodic_go(o_periodic_go), .o_ls_start_ok(o_ls_start_ok),
		.o_power_good_delay(o_power_good_delay), .o_no_power_switching(o_no_power_switching),
		.o_power_switch_mode(o_power_switch_mode), .o_pwr_per_port(o_pwr_per_port),
		.o_no_overcurrent_protect(o_no_overcurrent_protect),
		.o_overcurrent_report_mode(o_overcurrent_report_mode), .o_oc_per_port(o_oc_per_port),
		.o_oc_collective(o_oc_collective), .o_downstream_port_count(o_downstream_port_count));

	initial begin
		i_mclk = 1'b0;
		forever #2.5 i_mclk = ~i_mclk;
	end

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic test_done();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : test_done

	task automatic cyc(input int n);
		repeat (n) @(posedge i_mclk);
		#1;
	endtask : cyc

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_mclk);
		i_reg_wr <= 1'b1;
		i_reg_addr <= a;
		i_reg_wdata <= d;
		@(posedge i_mclk);
		i_reg_wr <= 1'b0;
	endtask : wr

	// The answer stands for one cycle only, so it is sampled just after the taking edge.
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge i_mclk);
		i_reg_rd <= 1'b1;
		i_reg_addr <= a;
		@(posedge i_mclk);
		i_reg_rd <= 1'b0;
		#1;
		chk("rvalid", 32'(o_reg_rvalid), 32'h1);
		chk("rdata", o_reg_rdata, exp);
	endtask : rd

	task automatic t_reset();
		rd(OFS_PER_START, 32'h0000_0000);
		rd(OFS_LS_THR, 32'h0000_0628);
		rd(OFS_RH_DESC_A, 32'hFF00_0903);
		rd(8'h4C, 32'h0000_0000);
		chk("overcurrent_report_mode", 32'(o_overcurrent_report_mode), 32'(PSM_RST));
		chk("ndp", 32'(o_downstream_port_count), 32'(NDP_TB));
		chk("pgd", 32'(o_power_good_delay), 32'h0000_00FF);
		$display("test reset done");
	endtask : t_reset

	task automatic desc_case(input logic [31:0] wd, input logic [31:0] rexp,
		input logic pp, input logic ocp, input logic occ);
		wr(OFS_RH_DESC_A, wd);
		cyc(3);
		chk("pwr_per_port", 32'(o_pwr_per_port), 32'(pp));
		chk("oc_per_port", 32'(o_oc_per_port), 32'(ocp));
		chk("oc_collective", 32'(o_oc_collective), 32'(occ));
		chk("pgd", 32'(o_power_good_delay), 32'(wd[31:24]));
		chk("no_overcurrent_protect", 32'(o_no_overcurrent_protect), 32'(wd[12]));
		chk("overcurrent_report_mode", 32'(o_overcurrent_report_mode), 32'(wd[11]));
		chk("nps", 32'(o_no_power_switching), 32'(wd[9]));
		chk("psm", 32'(o_power_switch_mode), 32'(wd[8]));
		rd(OFS_RH_DESC_A, rexp);
	endtask : desc_case

	task automatic t_desc();
		desc_case(32'hFF00_1FFF, 32'hFF00_1B03, 1'b0, 1'b0, 1'b0);
		desc_case(32'h0000_0000, 32'h0000_0003, 1'b0, 1'b0, 1'b1);
		desc_case(32'h5A00_0900, 32'h5A00_0903, 1'b1, 1'b1, 1'b0);
		desc_case(32'h0000_0200, 32'h0000_0203, 1'b0, 1'b0, 1'b1);
		$display("test descriptor done");
	endtask : t_desc

	task automatic t_ls();
		wr(OFS_LS_THR, 32'h0000_0FFF);
		rd(OFS_LS_THR, 32'h0000_0FFF);
		wr(OFS_LS_THR, 32'h0000_0100);
		i_frame_remaining <= 14'h0100;
		cyc(2);
		chk("ls_ok equal", 32'(o_ls_start_ok), 32'h1);
		i_frame_remaining <= 14'h00FF;
		cyc(2);
		chk("ls_ok below", 32'(o_ls_start_ok), 32'h0);
		$display("test low speed done");
	endtask : t_ls

	task automatic t_periodic();
		int n;
		wr(OFS_PER_START, 32'h0000_3FFF);
		rd(OFS_PER_START, 32'h0000_3FFF);
		wr(OFS_PER_START, 32'h0000_3E67);
		rd(OFS_PER_START, 32'h0000_3E67);
		wr(OFS_PER_START, 32'h0000_0010);
		i_frame_start <= 1'b1;
		i_frame_remaining <= 14'h0020;
		@(posedge i_mclk);
		i_frame_start <= 1'b0;
		i_frame_remaining <= 14'h0011;
		i_xfer_busy <= 1'b1;
		cyc(2);
		chk("priority early", 32'(o_periodic_priority), 32'h0);
		i_frame_remaining <= 14'h0010;
		@(posedge i_mclk);
		i_frame_remaining <= 14'h000F;
		cyc(1);
		chk("priority", 32'(o_periodic_priority), 32'h1);
		chk("go busy", 32'(o_periodic_go), 32'h0);
		i_xfer_busy <= 1'b0;
		n = 0;
		while (o_periodic_go !== 1'b1 && n < 4) begin
			cyc(1);
			n++;
		end
		chk("go", 32'(o_periodic_go), 32'h1);
		if (o_periodic_go !== 1'b1) begin
			test_done();
		end
		chk("priority held", 32'(o_periodic_priority), 32'h1);
		i_frame_start <= 1'b1;
		i_frame_remaining <= 14'h3FFF;
		@(posedge i_mclk);
		i_frame_start <= 1'b0;
		cyc(2);
		chk("priority cleared", 32'(o_periodic_priority), 32'h0);
		chk("go cleared", 32'(o_periodic_go), 32'h0);
		i_frame_remaining <= 14'h0010;
		@(posedge i_mclk);
		i_frame_remaining <= 14'h000F;
		cyc(1);
		chk("priority idle", 32'(o_periodic_priority), 32'h1);
		chk("go idle", 32'(o_periodic_go), 32'h1);
		$display("test periodic done");
	endtask : t_periodic

	initial begin
		errors = 0;
		compares = 0;
		i_nrst = 1'b0;
		i_reg_wr = 1'b0;
		i_reg_rd = 1'b0;
		i_reg_addr = 8'h00;
		i_reg_wdata = 32'h0000_0000;
		i_frame_remaining = 14'h3FFF;
		i_frame_start = 1'b0;
		i_xfer_busy = 1'b0;
		repeat (12) @(posedge i_mclk);
		i_nrst <= 1'b1;
		t_reset();
		t_desc();
		t_ls();
		t_periodic();
		test_done();
	end
endmodule : testbench
